// ===== rtl/strap_pin_mux.sv
// Top of the strap-selected pin function block: strap latch, shared select/serial pins, reference output.
// Assumes the power-up event arrives as sys_rst and a serial core sits behind the i2c_* ports.
// Assumes the board holds the strap pin steady for the settle time after reset release.
`timescale 1ns/100ps
module strap_pin_mux
  import strap_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Strap pin, later the reference clock output
  input wire logic strap_refclk_pin_i,
  output logic strap_refclk_pin_o,
  output logic strap_refclk_pin_oe_n,
  // Shared pin: select high bit or SDA
  input wire logic shared_hi_pin_i,
  output logic shared_hi_pin_o,
  output logic shared_hi_pin_oe_n,
  // Shared pin: select low bit or SCL
  input wire logic shared_lo_pin_i,
  output logic shared_lo_pin_o,
  output logic shared_lo_pin_oe_n,
  // Reference sources
  input wire logic xtal_clk_in,
  input wire logic ext_clk_in,
  input wire logic ref_select_ext,
  // Decoded configuration select
  output logic config_select_hi,
  output logic config_select_lo,
  output logic config_select_valid,
  // Serial core side
  output logic i2c_mode,
  output logic i2c_sda_in,
  output logic i2c_scl_in,
  input wire logic i2c_sda_drive_low,
  input wire logic i2c_scl_drive_low,
  // Power-up sampling status
  output logic strap_sampled
);
  // Carrier to the strap latch
  strap_if sif ();

  logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg;
  logic [SYNC_W-1:0] filt_reg, filt_next;
  logic ref_o_reg, ref_o_next;
  logic ref_oe_n_reg, ref_oe_n_next;
  logic hi_oe_n_reg, hi_oe_n_next;
  logic lo_oe_n_reg, lo_oe_n_next;
  logic pin_o_reg, pin_o_next;
  logic sel_hi_reg, sel_hi_next;
  logic sel_lo_reg, sel_lo_next;
  logic sel_valid_reg, sel_valid_next;
  logic i2c_mode_reg, i2c_mode_next;
  logic sda_in_reg, sda_in_next;
  logic scl_in_reg, scl_in_next;
  logic sampled_reg, sampled_next;
  logic ref_src;

  assign sif.strap_raw = strap_refclk_pin_i;

  // Strap sampling and latch
  strap_sampler u_sampler (
    .clk(clk),
    .sys_rst(sys_rst),
    .sif(sif)
  );

  // Three-stage synchronisers for the shared pins, reference clocks and source select; the strap pin has its own in the sampler
  // Reference clocks ride the same chain, so the output copy is only as fine as the system clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg <= SYNC_RST;
      s2_reg <= SYNC_RST;
      s3_reg <= SYNC_RST;
    end else begin
      s1_reg <= {shared_lo_pin_i, shared_hi_pin_i, ref_select_ext, ext_clk_in, xtal_clk_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Filtered levels: a change counts once stages two and three agree
  always_comb begin
    for (int i = 0; i < SYNC_W; i++) begin
      filt_next[i] = agree(s2_reg[i], s3_reg[i], filt_reg[i]);
    end
  end

  // Filter state; reset to the idle pin levels
  // so that no false change shows right after reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt_reg <= SYNC_RST;
    end else begin
      filt_reg <= filt_next;
    end
  end

  // Source switch is not glitch free; a runt pulse may reach the pin
  // crystal unless external chosen
  assign ref_src = filt_reg[SYNC_REFSEL] ? filt_reg[SYNC_EXT] : filt_reg[SYNC_XTAL];

  // Mode flags from the latched strap; both low until sampling ends
  always_comb begin
    sampled_next = sif.sample_done;
    sel_valid_next = 1'b0;
    i2c_mode_next = 1'b0;
    if (sif.sample_done) begin
      sel_valid_next = sif.strap_high;
      i2c_mode_next = ~sif.strap_high;
    end
  end

  // Mode flag registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sampled_reg <= 1'b0;
      sel_valid_reg <= 1'b0;
      i2c_mode_reg <= 1'b0;
    end else begin
      sampled_reg <= sampled_next;
      sel_valid_reg <= sel_valid_next;
      i2c_mode_reg <= i2c_mode_next;
    end
  end

  // Strap pin released before the latch, so only the board pull sets the sampled level
  always_comb begin
    ref_o_next = 1'b0;
    ref_oe_n_next = OE_N_RST;
    if (sif.sample_done) begin
      ref_oe_n_next = 1'b0;
      ref_o_next = ref_src;
    end
  end

  // Strap pin drive registers; no decode glitch reaches the pin
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_o_reg <= 1'b0;
      ref_oe_n_reg <= OE_N_RST;
    end else begin
      ref_o_reg <= ref_o_next;
      ref_oe_n_reg <= ref_oe_n_next;
    end
  end

  // Shared pins: filtered select levels or open-drain serial lines
  always_comb begin
    hi_oe_n_next = OE_N_RST;
    lo_oe_n_next = OE_N_RST;
    pin_o_next = 1'b0; // Open drain: only ever pulls low
    sel_hi_next = 1'b0;
    sel_lo_next = 1'b0;
    sda_in_next = LINE_IDLE;
    scl_in_next = LINE_IDLE;
    if (sif.sample_done) begin
      if (sif.strap_high) begin
        sel_hi_next = filt_reg[SYNC_PIN_HI];
        sel_lo_next = filt_reg[SYNC_PIN_LO];
      end else begin
        sda_in_next = filt_reg[SYNC_PIN_HI];
        scl_in_next = filt_reg[SYNC_PIN_LO];
        hi_oe_n_next = ~i2c_sda_drive_low;
        lo_oe_n_next = ~i2c_scl_drive_low;
      end
    end
  end

  // Shared pin registers; drive enables trail the serial core by one cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_oe_n_reg <= OE_N_RST;
      lo_oe_n_reg <= OE_N_RST;
      pin_o_reg <= 1'b0;
      sel_hi_reg <= 1'b0;
      sel_lo_reg <= 1'b0;
      sda_in_reg <= LINE_IDLE;
      scl_in_reg <= LINE_IDLE;
    end else begin
      hi_oe_n_reg <= hi_oe_n_next;
      lo_oe_n_reg <= lo_oe_n_next;
      pin_o_reg <= pin_o_next;
      sel_hi_reg <= sel_hi_next;
      sel_lo_reg <= sel_lo_next;
      sda_in_reg <= sda_in_next;
      scl_in_reg <= scl_in_next;
    end
  end

  // Strap pin drive
  assign strap_refclk_pin_o = ref_o_reg;
  assign strap_refclk_pin_oe_n = ref_oe_n_reg;

  // Shared pins share one low level; only the enables differ
  assign shared_hi_pin_o = pin_o_reg;
  assign shared_hi_pin_oe_n = hi_oe_n_reg;
  assign shared_lo_pin_o = pin_o_reg;
  assign shared_lo_pin_oe_n = lo_oe_n_reg;

  // Decoded select and serial side
  assign config_select_hi = sel_hi_reg;
  assign config_select_lo = sel_lo_reg;
  assign config_select_valid = sel_valid_reg;
  assign i2c_mode = i2c_mode_reg;
  assign i2c_sda_in = sda_in_reg;
  assign i2c_scl_in = scl_in_reg;

  // Latch status
  assign strap_sampled = sampled_reg;
endmodule : strap_pin_mux

// ===== include/strap_pkg.sv
// Constants for the power-up strap sampler and shared-pin mux.
// Assumes a single 125 MHz system clock and an active-high reset.
package strap_pkg;
  // System clock period
  localparam int CLK_PERIOD_NS = 8;
  // Strap level must stay stable this long before it is latched
  localparam int STRAP_SETTLE_NS = 1000;
  // Least time, rounded up to whole cycles
  localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W = 8;
  localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(STRAP_SETTLE_CYCLES - 1);
  localparam logic [SETTLE_CNT_W-1:0] SETTLE_CNT_RST = 8'h00;

  // Synchronised input vector layout in the mux
  localparam int SYNC_W = 5;
  localparam int SYNC_XTAL = 0;
  localparam int SYNC_EXT = 1;
  localparam int SYNC_REFSEL = 2;
  localparam int SYNC_PIN_HI = 3;
  localparam int SYNC_PIN_LO = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h18; // Shared pins idle high

  // Reset values
  localparam logic STRAP_LEVEL_RST = 1'b0; // Internal pull-down default
  localparam logic OE_N_RST = 1'b1;        // Not driving
  localparam logic LINE_IDLE = 1'b1;       // Released open-drain line

  // Sampler states
  typedef enum logic [1:0] {
    SMP_SETTLE = 2'b01,
    SMP_DONE = 2'b10
  } smp_state_t;

  // Second and third synchroniser stages must agree before a change counts
  function automatic logic agree(input logic s2, input logic s3, input logic prev);
    agree = (s2 == s3) ? s3 : prev;
  endfunction : agree
endpackage : strap_pkg

// ===== include/strap_if.sv
// Carrier between the shared-pin mux and the strap sampler.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface strap_if;
  logic strap_raw;
  logic sample_done;
  logic strap_high;
  modport sampler (input strap_raw, output sample_done, output strap_high);
  modport user (output strap_raw, input sample_done, input strap_high);
endinterface : strap_if

// ===== rtl/strap_sampler.sv
// Power-up strap sampler: synchronises the strap pin, waits for it to settle and latches it once.
// Assumes the strap pin is not driven by this device until sample_done is high.
`timescale 1ns/100ps
module strap_sampler
  import strap_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Carrier to the mux
  strap_if.sampler sif
);
  logic s1_reg, s2_reg, s3_reg;
  logic level_reg, level_next;
  logic high_reg, high_next;
  logic [SETTLE_CNT_W-1:0] cnt_reg, cnt_next;
  smp_state_t state_reg, state_next;

  // Three-stage synchroniser; stage one feeds only stage two
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg <= STRAP_LEVEL_RST;
      s2_reg <= STRAP_LEVEL_RST;
      s3_reg <= STRAP_LEVEL_RST;
    end else begin
      s1_reg <= sif.strap_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Settle counting and one-time latch
  always_comb begin
    level_next = agree(s2_reg, s3_reg, level_reg);
    cnt_next = cnt_reg;
    high_next = high_reg;
    state_next = state_reg;
    case (state_reg)
      SMP_SETTLE: begin
        if (level_next != level_reg) begin
          cnt_next = SETTLE_CNT_RST; // Bouncing strap restarts the wait
        end else if (cnt_reg == SETTLE_LAST) begin
          high_next = level_reg;
          state_next = SMP_DONE;
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      SMP_DONE: begin
        high_next = high_reg;
        state_next = SMP_DONE;
      end
      default: begin
        cnt_next = SETTLE_CNT_RST;
        state_next = SMP_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_reg <= STRAP_LEVEL_RST;
      high_reg <= STRAP_LEVEL_RST;
      cnt_reg <= SETTLE_CNT_RST;
      state_reg <= SMP_SETTLE;
    end else begin
      level_reg <= level_next;
      high_reg <= high_next;
      cnt_reg <= cnt_next;
      state_reg <= state_next;
    end
  end

  assign sif.sample_done = (state_reg == SMP_DONE);
  assign sif.strap_high = high_reg;
endmodule : strap_sampler

// ===== dv/strap_pin_mux_monitor.sv
// Port-level checker for the strap pin function mux.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/100ps
module strap_pin_mux_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic strap_sampled,
  input wire logic i2c_mode,
  input wire logic config_select_valid,
  input wire logic strap_refclk_pin_oe_n,
  input wire logic strap_refclk_pin_o,
  input wire logic xtal_clk_in,
  input wire logic ref_select_ext,
  input wire logic i2c_sda_drive_low,
  input wire logic shared_hi_pin_oe_n,
  input wire logic i2c_scl_drive_low,
  input wire logic shared_lo_pin_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Exactly one pin function once latched
  chk_one_mode: assert property (strap_sampled |-> config_select_valid != i2c_mode)
    else $error("mode flags disagree with latch");
  // Select high-bit pin is never driven
  chk_sel_input: assert property (config_select_valid |-> strap_sampled && shared_hi_pin_oe_n)
    else $error("select mode pin driven");
  chk_sda_pull: assert property (i2c_mode && i2c_sda_drive_low |=> !shared_hi_pin_oe_n)
    else $error("data line not pulled low");
  chk_scl_pull: assert property (i2c_mode && i2c_scl_drive_low |=> !shared_lo_pin_oe_n)
    else $error("clock line not pulled low");
  chk_ref_drive: assert property (strap_sampled == !strap_refclk_pin_oe_n)
    else $error("strap pin drive wrong");
  // Five-cycle path from the crystal to the pin
  chk_ref_follow: assert property (strap_sampled && $past(strap_sampled, 6) && !ref_select_ext
    && !$past(ref_select_ext, 5) |-> strap_refclk_pin_o == $past(xtal_clk_in, 5))
    else $error("reference output not following crystal");
  chk_latch_hold: assert property (strap_sampled |=> strap_sampled && $stable(i2c_mode))
    else $error("latched function changed");
endmodule : strap_pin_mux_monitor
bind strap_pin_mux strap_pin_mux_monitor mon (.clk, .sys_rst, .strap_sampled, .i2c_mode,
  .config_select_valid, .strap_refclk_pin_oe_n, .strap_refclk_pin_o, .xtal_clk_in,
  .ref_select_ext, .i2c_sda_drive_low, .shared_hi_pin_oe_n, .i2c_scl_drive_low,
  .shared_lo_pin_oe_n);

// ===== dv/strap_board_model.sv
// Board model: strap pull resistor and host on the shared pins.
// Assumes pins split into input, output and active-low enable.
`timescale 1ns/100ps
module strap_board_model (
  // Board setup
  input wire logic pull_up,
  input wire logic host_hi,
  input wire logic host_lo,
  // Device drive
  input wire logic strap_o,
  input wire logic strap_oe_n,
  input wire logic hi_oe_n,
  input wire logic lo_oe_n,
  // Resolved levels
  output logic strap_pin,
  output logic hi_pin,
  output logic lo_pin
);
  // Weak pull loses once the device drives
  assign strap_pin = strap_oe_n ? pull_up : strap_o;
  // Open-drain lines, high unless pulled low
  assign hi_pin = host_hi & hi_oe_n;
  assign lo_pin = host_lo & lo_oe_n;
endmodule : strap_board_model

// ===== dv/tb_strap_pin_mux.sv
// Self-checking bench for the strap pin function mux.
// Assumes a 125 MHz clock and a 25 MHz crystal.
`timescale 1ns/100ps
module tb_strap_pin_mux;
  logic clk, sys_rst, xtal_clk_in, ext_clk_in, ref_select_ext, pull_up, host_hi, host_lo;
  logic i2c_sda_drive_low, i2c_scl_drive_low, strap_refclk_pin_i, strap_refclk_pin_o;
  logic strap_refclk_pin_oe_n, shared_hi_pin_i, shared_hi_pin_o, shared_hi_pin_oe_n;
  logic shared_lo_pin_i, shared_lo_pin_o, shared_lo_pin_oe_n, config_select_hi;
  logic config_select_lo, config_select_valid, i2c_mode, i2c_sda_in, i2c_scl_in, strap_sampled;
  int err_count = 0, num_checks = 0, cycles = 0;
  strap_pin_mux dut (.clk, .sys_rst, .strap_refclk_pin_i, .strap_refclk_pin_o,
    .strap_refclk_pin_oe_n, .shared_hi_pin_i, .shared_hi_pin_o, .shared_hi_pin_oe_n,
    .shared_lo_pin_i, .shared_lo_pin_o, .shared_lo_pin_oe_n, .xtal_clk_in, .ext_clk_in,
    .ref_select_ext, .config_select_hi, .config_select_lo, .config_select_valid, .i2c_mode,
    .i2c_sda_in, .i2c_scl_in, .i2c_sda_drive_low, .i2c_scl_drive_low, .strap_sampled);
  strap_board_model board (.pull_up, .host_hi, .host_lo, .strap_o(strap_refclk_pin_o),
    .strap_oe_n(strap_refclk_pin_oe_n), .hi_oe_n(shared_hi_pin_oe_n), .lo_oe_n(shared_lo_pin_oe_n),
    .strap_pin(strap_refclk_pin_i), .hi_pin(shared_hi_pin_i), .lo_pin(shared_lo_pin_i));
  // Clocks: system, crystal, external near 9.6 MHz; references start 1 ns late so no toggle meets a rising edge
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    xtal_clk_in = 0;
    #1;
    forever #20 xtal_clk_in = ~xtal_clk_in;
  end
  initial begin
    ext_clk_in = 0;
    #1;
    forever #52 ext_clk_in = ~ext_clk_in;
  end
  task automatic check(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : check
  task automatic wrap_up;
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  // Power-up with a strap level, then disturb the pull
  task automatic power_up(input logic lvl);
    int n;
    n = 0;
    @(posedge clk);
    sys_rst <= 1;
    pull_up <= lvl;
    repeat (20) @(posedge clk);
    sys_rst <= 0;
    while (strap_sampled !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check(n >= strap_pkg::STRAP_SETTLE_CYCLES && n <= strap_pkg::STRAP_SETTLE_CYCLES + 8, 1, "latch time");
    check(config_select_valid, lvl, "select mode");
    check(i2c_mode, !lvl, "serial mode");
    check(strap_refclk_pin_oe_n, 0, "strap pin not driven");
    pull_up <= !lvl;
    repeat (150) @(posedge clk);
    check(i2c_mode, !lvl, "function changed after latch");
    check(config_select_valid, lvl, "select mode changed after latch");
  endtask : power_up
  // All four select codes
  task automatic select_codes;
    for (int v = 0; v < 4; v++) begin
      host_hi <= v[1];
      host_lo <= v[0];
      repeat (8) @(posedge clk);
      check(config_select_hi, v[1], "select high bit");
      check(config_select_lo, v[0], "select low bit");
      check(shared_hi_pin_oe_n & shared_lo_pin_oe_n, 1, "select pin driven");
    end
  endtask : select_codes
  // Device pulls data, host pulls clock
  task automatic serial_lines;
    i2c_sda_drive_low <= 1;
    host_lo <= 0;
    repeat (8) @(posedge clk);
    check(shared_hi_pin_oe_n, 0, "data not pulled");
    check(i2c_sda_in, 0, "data level");
    check(i2c_scl_in, 0, "clock level");
    check(shared_hi_pin_o | shared_lo_pin_o, 0, "open drain drove high");
    i2c_sda_drive_low <= 0;
    i2c_scl_drive_low <= 1;
    host_lo <= 1;
    repeat (8) @(posedge clk);
    check(shared_lo_pin_oe_n, 0, "clock not pulled");
    check(i2c_sda_in, 1, "data not released");
    i2c_scl_drive_low <= 0;
    repeat (8) @(posedge clk);
    check(i2c_sda_in & i2c_scl_in, 1, "lines not released");
  endtask : serial_lines
  // Rising edges of the output over 4000 ns
  task automatic ref_rate(input logic ext, input int exp);
    int k;
    logic prev;
    k = 0;
    ref_select_ext <= ext;
    repeat (20) @(posedge clk);
    prev = strap_refclk_pin_o;
    repeat (500) begin
      @(posedge clk);
      if (strap_refclk_pin_o && !prev) k++;
      prev = strap_refclk_pin_o;
    end
    check(k >= exp - 1 && k <= exp + 1, 1, "reference rate");
  endtask : ref_rate
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    sys_rst = 1;
    pull_up = 1;
    host_hi = 1;
    host_lo = 1;
    ref_select_ext = 0;
    i2c_sda_drive_low = 0;
    i2c_scl_drive_low = 0;
    power_up(1);
    select_codes();
    ref_rate(0, 100);
    power_up(0);
    serial_lines();
    ref_rate(1, 38);
    wrap_up();
  end
endmodule : tb_strap_pin_mux
